// ---- design/monitor_irq_pkg.sv ----
// constants for the hardware monitor interrupt status and mask block
package monitor_irq_pkg;
	// register index as seen on the address pointer
	localparam logic [7:0] EVENT_STATUS_TWO_ADDR = 8'h02;
	localparam logic [7:0] EVENT_MASK_ONE_ADDR   = 8'h03;
	localparam logic [7:0] EVENT_MASK_TWO_ADDR   = 8'h44;
	// power-on values
	localparam logic [7:0] EVENT_STATUS_TWO_RST  = 8'h00;
	localparam logic [7:0] EVENT_MASK_ONE_RST    = 8'h00;
	localparam logic [7:0] EVENT_MASK_TWO_RST    = 8'h00;
	localparam logic [7:0] REG_READ_ZERO         = 8'h00;
	// status two field positions (mask two uses the same for bits 0-5)
	localparam int HOT_BIT     = 0;
	localparam int ALERT_BIT   = 1;
	localparam int TACH_INPUT_1_BIT    = 2;
	localparam int TACH_INPUT_2_BIT    = 3;
	localparam int CHASSIS_BIT = 4;
	localparam int OVERTEMP_BIT = 5;
	localparam int EVENT_BITS  = 6;
	// mode select fields in mask two
	localparam int HOT_MODE_BIT      = 6;
	localparam int OVERTEMP_MODE_BIT = 7;
	// temperature channel index
	localparam int TEMP_HOT      = 0;
	localparam int TEMP_OVERTEMP = 1;
	localparam int TEMP_CHANNELS = 2;
	// mask one field for the external interrupt input
	localparam int INT_IN_BIT = 7;
endpackage

// ---- design/monitor_interrupt_status_mask.sv ----
// interrupt status two, mask one and mask two with the interrupt output
//
// Operation
// - status bit 0 sets on hot limit crossing; host cannot write it.
// - hot status supports one-time and default modes, chosen by mask two bit 6.
// - status bit 1 sets while the active-low board alert pin is low.
// - status bits 2 and 3 set when tach channel 1 or 2 exceeds limit.
// - status bit 4 sets when chassis intrusion input is high.
// - status bit 5 sets on overtemperature limit crossing, comparator fashion, in default or one-time mode.
// - overtemperature status mode chosen by mask two bit 7.
// - a mask bit of one keeps its status bit off the interrupt.
// - mask two sits at index 44h; bit 0 hot, bit 1 board alert.
// - status two, mask one and mask two reset to zero.
// - default mode: read clears, each conversion sets again until below hysteresis.
// - one-time mode: one event per excursion, rearmed only below hysteresis.
`timescale 1ns/100ps
module monitor_interrupt_status_mask
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       conv_done,
	input  wire logic [1:0] temp_above,
	input  wire logic [1:0] temp_below_hyst,
	input  wire logic       tach_1_over,
	input  wire logic       tach_2_over,
	input  wire logic [6:0] voltage_status,
	input  wire logic       int_in_status,
	input  wire logic       board_temp_alert_in_n,
	input  wire logic       chassis_intrusion_in,
	output logic            event_irq
);
	logic [7:0] event_status_two;
	logic [7:0] next_event_status_two;
	logic [7:0] event_mask_one;
	logic [7:0] next_event_mask_one;
	logic [7:0] event_mask_two;
	logic [7:0] next_event_mask_two;
	logic [7:0] next_reg_rdata;
	logic       next_event_irq;
	logic       alert_meta;
	logic       alert_sync_n;
	logic       chassis_meta;
	logic       chassis_sync;
	logic [1:0] temp_event;
	logic [1:0] one_time_mode;
	logic       status_read;
	logic [7:0] pending_one;
	logic [5:0] pending_two;

	// pins from outside pass two flops before use
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			alert_meta   <= 1'b1;
			alert_sync_n <= 1'b1;
			chassis_meta <= 1'b0;
			chassis_sync <= 1'b0;
		end
		else
		begin
			alert_meta   <= board_temp_alert_in_n;
			alert_sync_n <= alert_meta;
			chassis_meta <= chassis_intrusion_in;
			chassis_sync <= chassis_meta;
		end
	end

	assign status_read = reg_rd && (reg_addr == monitor_irq_pkg::EVENT_STATUS_TWO_ADDR);
	assign one_time_mode[monitor_irq_pkg::TEMP_HOT] =
		event_mask_two[monitor_irq_pkg::HOT_MODE_BIT];
	assign one_time_mode[monitor_irq_pkg::TEMP_OVERTEMP] =
		event_mask_two[monitor_irq_pkg::OVERTEMP_MODE_BIT];

	// per temperature channel: window tracking and one-time arming
	genvar ch;
	generate
		for (ch = 0; ch < monitor_irq_pkg::TEMP_CHANNELS; ch++)
		begin : g_temp
			logic over_active;
			logic next_over_active;
			logic armed;
			logic next_armed;
			logic fire;

			// comparator fashion: above limit until below hysteresis
			always_comb
			begin
				next_over_active = over_active;
				next_armed       = armed;
				fire             = 1'b0;
				if (conv_done)
				begin
					if (temp_below_hyst[ch])
					begin
						next_over_active = 1'b0;
						next_armed       = 1'b1;
					end
					else if (temp_above[ch] || over_active)
					begin
						next_over_active = 1'b1;
						if (!one_time_mode[ch])
							fire = 1'b1;
						else if (armed)
						begin
							fire       = 1'b1;
							next_armed = 1'b0;
						end
					end
				end
			end

			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					over_active <= 1'b0;
					armed       <= 1'b1;
				end
				else
				begin
					over_active <= next_over_active;
					armed       <= next_armed;
				end
			end

			assign temp_event[ch] = fire;
		end
	endgenerate

	// pending unmasked events of both status registers
	assign pending_one = {int_in_status, voltage_status} & ~event_mask_one;
	assign pending_two = event_status_two[5:0] & ~event_mask_two[5:0];

	// next register values, read data and interrupt
	always_comb
	begin
		next_event_status_two = event_status_two;
		next_event_mask_one   = event_mask_one;
		next_event_mask_two   = event_mask_two;
		next_reg_rdata        = reg_rdata;
		// reading status two clears it; events below win over the clear
		if (status_read)
			next_event_status_two = monitor_irq_pkg::EVENT_STATUS_TWO_RST;
		if (temp_event[monitor_irq_pkg::TEMP_HOT])
			next_event_status_two[monitor_irq_pkg::HOT_BIT] = 1'b1;
		if (!alert_sync_n)
			next_event_status_two[monitor_irq_pkg::ALERT_BIT] = 1'b1;
		if (tach_1_over)
			next_event_status_two[monitor_irq_pkg::TACH_INPUT_1_BIT] = 1'b1;
		if (tach_2_over)
			next_event_status_two[monitor_irq_pkg::TACH_INPUT_2_BIT] = 1'b1;
		if (chassis_sync)
			next_event_status_two[monitor_irq_pkg::CHASSIS_BIT] = 1'b1;
		if (temp_event[monitor_irq_pkg::TEMP_OVERTEMP])
			next_event_status_two[monitor_irq_pkg::OVERTEMP_BIT] = 1'b1;
		next_event_status_two[7:6] = 2'h0;
		// mask writes; a write to status two is dropped
		if (reg_wr && (reg_addr == monitor_irq_pkg::EVENT_MASK_ONE_ADDR))
			next_event_mask_one = reg_wdata;
		if (reg_wr && (reg_addr == monitor_irq_pkg::EVENT_MASK_TWO_ADDR))
			next_event_mask_two = reg_wdata;
		if (reg_rd)
		begin
			unique case (reg_addr)
				monitor_irq_pkg::EVENT_STATUS_TWO_ADDR: next_reg_rdata = event_status_two;
				monitor_irq_pkg::EVENT_MASK_ONE_ADDR:   next_reg_rdata = event_mask_one;
				monitor_irq_pkg::EVENT_MASK_TWO_ADDR:   next_reg_rdata = event_mask_two;
				default:                                next_reg_rdata = monitor_irq_pkg::REG_READ_ZERO;
			endcase
		end
		next_event_irq = (|pending_one) || (|pending_two);
	end

	// register stage
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			event_status_two <= monitor_irq_pkg::EVENT_STATUS_TWO_RST;
			event_mask_one   <= monitor_irq_pkg::EVENT_MASK_ONE_RST;
			event_mask_two   <= monitor_irq_pkg::EVENT_MASK_TWO_RST;
			reg_rdata        <= monitor_irq_pkg::REG_READ_ZERO;
			event_irq        <= 1'b0;
		end
		else
		begin
			event_status_two <= next_event_status_two;
			event_mask_one   <= next_event_mask_one;
			event_mask_two   <= next_event_mask_two;
			reg_rdata        <= next_reg_rdata;
			event_irq        <= next_event_irq;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// reserved bits of status two always read zero
	status_reserved_a: assert property (status_read |=> reg_rdata[7:6] == 2'h0)
		else $error("reserved status bits read nonzero");
	// unmasked pending event raises the output next cycle
	irq_raise_a: assert property ((|pending_two) || (|pending_one) |=> event_irq)
		else $error("interrupt missing for unmasked event");
	// output only follows an unmasked pending event
	irq_masked_a: assert property (event_irq |-> $past(|pending_two || |pending_one))
		else $error("interrupt raised with all events masked");
	// board alert low sets bit 1 even across a read
	alert_set_a: assert property (!alert_sync_n |=> event_status_two[1])
		else $error("board alert not latched");
	// chassis intrusion sets bit 4
	chassis_set_a: assert property (chassis_sync |=> event_status_two[4])
		else $error("chassis intrusion not latched");
	// tach limits set bits 2 and 3, each on its own
	tach_input_1_set_a: assert property (tach_1_over |=> event_status_two[2])
		else $error("fan one limit not latched");
	tach_input_2_set_a: assert property (tach_2_over |=> event_status_two[3])
		else $error("fan two limit not latched");
	// default overtemperature mode sets on each conversion above the limit
	overtemp_default_a: assert property (conv_done && temp_above[1] && !temp_below_hyst[1]
		&& !event_mask_two[7] |=> event_status_two[5])
		else $error("overtemperature event missed in default mode");
	// default hot mode sets on each conversion above the limit
	hot_default_a: assert property (conv_done && temp_above[0] && !temp_below_hyst[0]
		&& !event_mask_two[6] |=> event_status_two[0])
		else $error("hot event missed in default mode");
	// one-time hot mode stays quiet until rearmed below hysteresis
	hot_once_a: assert property (status_read && event_mask_two[6] && !g_temp[0].armed
		&& !temp_below_hyst[0] |=> !event_status_two[0] [*2])
		else $error("one-time hot event repeated");
	// read with no new event clears status two
	read_clear_a: assert property (status_read && !temp_event[0] && !temp_event[1]
		&& alert_sync_n && !tach_1_over && !tach_2_over && !chassis_sync
		|=> event_status_two == 8'h00)
		else $error("status not cleared by read");
	// a mask two write takes the written value
	mask_two_write_a: assert property (reg_wr && reg_addr == 8'h44
		|=> event_mask_two == $past(reg_wdata))
		else $error("mask two write lost");
endmodule

// ---- bench/monitor_host_model.sv ----
// host model driving the block's register index and strobe port
`timescale 1ns/100ps
module monitor_host_model
(
	input  wire logic       core_clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// idle port at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// one write pulse; released lines show inverted values
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// one read pulse; data is taken once the taking edge has landed
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ---- bench/monitor_interrupt_status_mask_bench.sv ----
// self-checking bench for the interrupt status and mask block
`timescale 1ns/100ps
module monitor_interrupt_status_mask_bench;
	localparam logic [7:0] st2 = monitor_irq_pkg::EVENT_STATUS_TWO_ADDR;
	localparam logic [7:0] mk1 = monitor_irq_pkg::EVENT_MASK_ONE_ADDR;
	localparam logic [7:0] mk2 = monitor_irq_pkg::EVENT_MASK_TWO_ADDR;
	logic       core_clk = 1'b0, rst = 1'b1, conv_done = 1'b0;
	logic [1:0] temp_above = 2'b00, temp_below_hyst = 2'b00;
	logic       tach_1_over = 1'b0, tach_2_over = 1'b0;
	logic [6:0] voltage_status = 7'h00;
	logic       int_in_status = 1'b0, chassis_intrusion_in = 1'b0;
	logic       board_temp_alert_in_n = 1'b1;
	logic       reg_wr, reg_rd, event_irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	int         fails = 0, check_count = 0, cycles = 0;
	// 50 ns clock
	always #25 core_clk = ~core_clk;
	monitor_interrupt_status_mask i_monitor_interrupt_status_mask
	(.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.conv_done, .temp_above, .temp_below_hyst, .tach_1_over, .tach_2_over,
		.voltage_status, .int_in_status, .board_temp_alert_in_n,
		.chassis_intrusion_in, .event_irq);
	monitor_host_model i_monitor_host_model
	(.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
	task automatic tally_and_finish();
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// compare one 8-bit result
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_monitor_host_model.write_reg(a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		i_monitor_host_model.read_reg(a, v);
		chk("read data", e, v);
	endtask
	task automatic irq(input logic e);
		chk("event_irq", {7'h00, e}, {7'h00, event_irq});
	endtask
	// one conversion pulse with its comparison levels
	task automatic conv(input logic [1:0] up, input logic [1:0] dn);
		@(negedge core_clk);
		temp_above = up;
		temp_below_hyst = dn;
		conv_done = 1'b1;
		@(negedge core_clk);
		conv_done = 1'b0;
	endtask
	// level sources: 1 alert, 2 tach 1, 3 tach 2, 4 chassis
	task automatic src(input int k, input logic on);
		@(negedge core_clk);
		board_temp_alert_in_n = !(on && k == 1);
		tach_1_over = on && k == 2;
		tach_2_over = on && k == 3;
		chassis_intrusion_in = on && k == 4;
	endtask
	// default then one-time mode for temperature channel c
	task automatic temp_seq(input int c);
		logic [7:0] b;
		logic [1:0] t;
		b = 8'h01 << (5 * c);
		t = 2'b01 << c;
		wr(mk2, 8'h00);
		conv(t, 2'b00);
		cyc(2);
		irq(1'b1);
		wr(mk2, b);
		cyc(2);
		irq(1'b0);
		wr(mk2, 8'h00);
		rd(st2, b);
		rd(st2, 8'h00);
		cyc(2);
		irq(1'b0);
		conv(t, 2'b00);
		rd(st2, b);
		conv(2'b00, t);
		conv(2'b00, 2'b00);
		rd(st2, 8'h00);
		wr(mk2, 8'h40 << c);
		conv(t, 2'b00);
		rd(st2, b);
		conv(t, 2'b00);
		rd(st2, 8'h00);
		conv(2'b00, t);
		conv(t, 2'b00);
		rd(st2, b);
		conv(2'b00, t);
	endtask
	// main sequence
	initial
	begin
		cyc(12);
		rst = 1'b0;
		irq(1'b0);
		rd(st2, 8'h00);
		rd(mk1, 8'h00);
		rd(mk2, 8'h00);
		wr(mk1, 8'hA5);
		wr(mk2, 8'h5A);
		wr(st2, 8'hFF);
		rd(mk1, 8'hA5);
		rd(mk2, 8'h5A);
		rd(st2, 8'h00);
		rd(8'h04, 8'h00);
		wr(mk2, 8'h00);
		wr(mk1, 8'h00);
		for (int k = 1; k < 5; k++)
		begin
			src(k, 1'b1);
			cyc(5);
			irq(1'b1);
			wr(st2, 8'h00);
			rd(st2, 8'h01 << k);
			wr(mk2, 8'h01 << k);
			cyc(2);
			irq(1'b0);
			src(k, 1'b0);
			wr(mk2, 8'h00);
			cyc(4);
			rd(st2, 8'h01 << k);
			rd(st2, 8'h00);
		end
		for (int k = 0; k < 8; k++)
		begin
			{int_in_status, voltage_status} = 8'h01 << k;
			cyc(3);
			irq(1'b1);
			wr(mk1, 8'h01 << k);
			cyc(2);
			irq(1'b0);
			{int_in_status, voltage_status} = 8'h00;
			wr(mk1, 8'h00);
		end
		temp_seq(0);
		temp_seq(1);
		// second reset in mid-run with masks programmed
		wr(mk1, 8'hFF);
		rst = 1'h1;
		cyc(2);
		rst = 1'h0;
		irq(1'h0);
		rd(mk1, 8'h00);
		rd(mk2, 8'h00);
		tally_and_finish();
	end
	// cut a hang short
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fails++;
			tally_and_finish();
		end
	end
endmodule
